// ===== dhl_pkg.sv
package dhl_pkg;

	localparam int         SER_BITS     = 8;
	localparam logic [2:0] SER_LAST     = 3'(SER_BITS - 1);
	localparam int         FMT_LSB      = 4;
	localparam logic [2:0] FMT_18BPP    = 3'h6;
	localparam logic [2:0] FMT_16BPP    = 3'h5;
	localparam int         WAKE_ZEROS   = 40;
	localparam logic [5:0] WAKE_ZC_LAST = 6'(WAKE_ZEROS - 1);

	localparam logic [2:0]  VDESC_TAG  = 3'b010;
	localparam logic [3:0]  COMP_5     = 4'h5;
	localparam logic [3:0]  COMP_6     = 4'h6;
	localparam logic [1:0]  ATTR_MEM   = 2'b11;
	localparam logic [1:0]  ATTR_SUB   = 2'b00;
	localparam logic [1:0]  RW_WRITE   = 2'b00;
	localparam logic [1:0]  RW_READ    = 2'b10;
	localparam logic [15:0] DEST_MAIN  = 16'h0000;
	localparam logic [15:0] DEST_SUB   = 16'h0001;

	localparam logic [15:0] PT_SUBFRAME  = 16'h3BFF;
	localparam logic [15:0] PT_REGACC    = 16'h0092;
	localparam logic [15:0] PT_VIDEO     = 16'h0010;
	localparam logic [15:0] PT_SHUTDOWN  = 16'h0045;
	localparam logic [15:0] SUBFRAME_LEN = 16'h0014;

	// Word positions inside a packet, length word is 0
	localparam logic [15:0] W_TYPE   = 16'h0001;
	localparam logic [15:0] W_CLIENT = 16'h0002;
	localparam logic [15:0] W_INFO   = 16'h0003;
	localparam logic [15:0] W_SEL    = 16'h0004;
	localparam logic [15:0] W_DEST   = 16'h0005;
	localparam logic [15:0] W_RPAR   = 16'h0007;
	localparam logic [15:0] W_VPIX   = 16'h000D;

	typedef struct packed {
		logic        vs_n;
		logic        hs_n;
		logic        de;
		logic        pclk;
		logic [17:0] data;
	} dhl_dpi_s;

	typedef struct packed {
		logic cs_n;
		logic scl;
		logic dcx;
		logic din;
	} dhl_ser_s;

	typedef struct packed {
		logic        fwd;
		logic [15:0] index;
	} dhl_regreq_s;

	typedef enum logic [1:0] {LK_WAKE, LK_SEEK, LK_PKT} dhl_link_e;

	function automatic logic [2:0] dhl_desc_fmt(input logic [15:0] desc);
		logic [2:0] f;
		f = 3'h0;
		if (desc[15:13] == VDESC_TAG && desc[12]) begin
			if (desc[11:0] == {COMP_5, COMP_6, COMP_5}) f = FMT_16BPP;
			else if (desc[11:0] == {COMP_6, COMP_6, COMP_6}) f = FMT_18BPP;
		end
		return f;
	endfunction
endpackage

// ===== dhl_sync.sv
`timescale 1ns/1ps
module dhl_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	// First stage is seen by the second stage only
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_r <= '0;
			o_q    <= '0;
		end else begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end
endmodule

// ===== dhl_deser.sv
`timescale 1ns/1ps
module dhl_deser (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_bit,
	input  wire logic        i_align,
	output logic      [31:0] o_win,
	output logic             o_stb
);
	logic [3:0] cnt_r;

	// Link is LSB first, so the newest bit enters at the top
	always_ff @(posedge i_clk) begin
		if (i_rst) o_win <= '0;
		else o_win <= {i_bit, o_win[31:1]};
	end

	// Align marks the bit now arriving as bit 0 of a word
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r <= '0;
			o_stb <= 1'b0;
		end else begin
			cnt_r <= i_align ? 4'h1 : cnt_r + 4'h1;
			o_stb <= !i_align && cnt_r == 4'hF;
		end
	end
endmodule

// ===== dhl_frontend.sv
`timescale 1ns/1ps
module dhl_frontend
	import dhl_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_mddi_clk,
	input  wire logic        i_mddi_data,
	input  wire dhl_ser_s    i_ser,
	input  wire logic [7:0]  i_rd_data,
	input  wire logic        i_rd_active,
	input  wire dhl_dpi_s    i_dpi,
	input  wire logic [7:0]  i_pixel_format,
	output logic             o_dout,
	output logic             o_dout_oe,
	output logic [7:0]       o_ser_byte,
	output logic             o_ser_valid,
	output logic             o_ser_cmd,
	output logic [7:0]       o_ser_index,
	output logic [17:0]      o_pix_data,
	output logic             o_pix_valid,
	output logic             o_frame_start,
	output logic             o_line_start,
	output logic             o_link_hib,
	output logic             o_subframe,
	output logic [15:0]      o_vid_word,
	output logic             o_vid_mem_we,
	output logic             o_vid_sub_we,
	output dhl_regreq_s      o_reg_req,
	output logic             o_reg_rd_req,
	output logic             o_reg_wr,
	output logic [15:0]      o_reg_data,
	output logic             o_reg_done
);
	localparam int PW = $bits(dhl_dpi_s) + $bits(dhl_ser_s);

	dhl_dpi_s      d;
	dhl_ser_s      s;
	logic [PW-1:0] pin_q;

	dhl_sync #(.W(PW)) u_pin_sync (
		.i_clk (i_clk),
		.i_rst (i_srst),
		.i_d   ({i_dpi, i_ser}),
		.o_q   (pin_q)
	);
	assign {d, s} = pin_q;

	// Serial port, oversampled: clock must stay well below a quarter of i_clk
	logic       scl_d_r;
	logic [2:0] bcnt_r;
	logic [6:0] sh_r;
	logic [7:0] rdb_r;
	logic [7:0] idx_r;
	logic       ser_rise;
	logic       byte_end;

	assign ser_rise = s.scl && !scl_d_r && !s.cs_n;
	assign byte_end = ser_rise && bcnt_r == SER_LAST;

	always_ff @(posedge i_clk) begin
		if (i_srst) scl_d_r <= 1'b0;
		else scl_d_r <= s.scl;
	end

	// Deselect always returns to bit 0; a partial byte is lost
	always_ff @(posedge i_clk) begin
		if (i_srst || s.cs_n) bcnt_r <= '0;
		else if (ser_rise) bcnt_r <= bcnt_r + 3'h1;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) sh_r <= '0;
		else if (ser_rise) sh_r <= {sh_r[5:0], s.din};
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_ser_valid <= 1'b0;
			o_ser_byte  <= '0;
			o_ser_cmd   <= 1'b0;
			o_ser_index <= '0;
		end else begin
			o_ser_valid <= byte_end;
			if (byte_end) begin
				o_ser_byte  <= {sh_r, s.din};
				o_ser_cmd   <= !s.dcx;
				o_ser_index <= s.dcx ? idx_r : 8'h00;
			end
		end
	end

	// Position survives a pause; only whole bytes move it
	always_ff @(posedge i_clk) begin
		if (i_srst) idx_r <= '0;
		else if (byte_end) idx_r <= s.dcx ? idx_r + 8'h01 : 8'h00;
	end

	// Data moves while the clock is low so it is steady at the rise
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rdb_r     <= '0;
			o_dout    <= 1'b0;
			o_dout_oe <= 1'b0;
		end else begin
			if (bcnt_r == 3'h0 && !s.scl) rdb_r <= i_rd_data;
			if (!s.scl) o_dout <= rdb_r[~bcnt_r];
			o_dout_oe <= !s.cs_n && i_rd_active;
		end
	end

	a_ser_break: assert property (
		@(posedge i_clk) disable iff (i_srst) s.cs_n |=> bcnt_r == 3'h0 && !o_ser_valid)
		else $error("deselect did not clear the bit count");
	a_ser_byte: assert property (
		@(posedge i_clk) disable iff (i_srst)
		ser_rise && bcnt_r == 3'h7 |=> o_ser_valid && o_ser_byte[0] == $past(s.din))
		else $error("eighth bit did not complete a byte");
	a_ser_pause: assert property (
		@(posedge i_clk) disable iff (i_srst) s.cs_n ##1 s.cs_n |-> $stable(idx_r))
		else $error("sequence position moved while deselected");
	a_ser_cmd: assert property (
		@(posedge i_clk) disable iff (i_srst) o_ser_valid && o_ser_cmd |-> idx_r == 8'h00)
		else $error("command byte did not restart the sequence");
	a_dout_oe: assert property (
		@(posedge i_clk) disable iff (i_srst) s.cs_n |=> !o_dout_oe)
		else $error("read data driven while deselected");
	c_ser_byte: cover property (@(posedge i_clk) disable iff (i_srst) o_ser_valid && !o_ser_cmd);

	// Pixel port, sampled on i_clk; pixel clock must stay under half of i_clk
	logic pclk_d_r;
	logic hs_d_r;
	logic vs_d_r;
	logic pix_rise;
	logic fmt16;

	assign pix_rise = d.pclk && !pclk_d_r;
	assign fmt16    = i_pixel_format[FMT_LSB +: 3] == FMT_16BPP;

	always_ff @(posedge i_clk) begin
		// Reset matches the cleared synchroniser, so no false sync edge follows
		if (i_srst) begin
			pclk_d_r <= 1'b0;
			hs_d_r   <= 1'b0;
			vs_d_r   <= 1'b0;
		end else begin
			pclk_d_r <= d.pclk;
			hs_d_r   <= d.hs_n;
			vs_d_r   <= d.vs_n;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_frame_start <= 1'b0;
			o_line_start  <= 1'b0;
		end else begin
			o_frame_start <= vs_d_r && !d.vs_n;
			o_line_start  <= hs_d_r && !d.hs_n;
		end
	end

	// Pixel clock is free running, so enable at a pixel clock rise marks a pixel
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_pix_valid <= 1'b0;
			o_pix_data  <= '0;
		end else begin
			o_pix_valid <= pix_rise && d.de;
			if (pix_rise && d.de) o_pix_data <= fmt16 ? {2'b00, d.data[15:0]} : d.data;
		end
	end

	a_pix_de: assert property (
		@(posedge i_clk) disable iff (i_srst) o_pix_valid |-> $past(pix_rise) && $past(d.de))
		else $error("pixel taken without enable or clock rise");
	a_pix_fmt: assert property (
		@(posedge i_clk) disable iff (i_srst)
		pix_rise && d.de && fmt16 |=> o_pix_data == {2'b00, $past(d.data[15:0])})
		else $error("16bpp pixel not packed into low bits");
	a_frame_start: assert property (
		@(posedge i_clk) disable iff (i_srst) vs_d_r && !d.vs_n |=> o_frame_start ##1 !o_frame_start)
		else $error("vertical sync edge did not give one start pulse");
	c_pix_line: cover property (@(posedge i_clk) disable iff (i_srst)
		o_line_start ##[1:40] o_pix_valid);

	// Link domain: format is quasi-static, so a plain two-stage hop is enough
	logic [3:0]  lk_q;
	logic        lrst;
	logic [2:0]  lfmt;
	logic [31:0] win;
	logic        w_stb;
	logic [15:0] w_word;
	logic        hib_r;

	dhl_sync #(.W(4)) u_link_sync (
		.i_clk (i_mddi_clk),
		.i_rst (1'b0),
		.i_d   ({i_srst, i_pixel_format[FMT_LSB +: 3]}),
		.o_q   (lk_q)
	);
	assign lrst   = lk_q[3];
	assign lfmt   = lk_q[2:0];
	assign w_word = win[31:16];

	dhl_sync #(.W(1)) u_hib_sync (
		.i_clk (i_clk),
		.i_rst (i_srst),
		.i_d   (hib_r),
		.o_q   (o_link_hib)
	);

	dhl_link_e   lst_r;
	logic [5:0]  zc_r;
	logic [15:0] wc_r;
	logic [15:0] len_r;
	logic [15:0] type_r;
	logic [15:0] sel_r;
	logic [15:0] dest_r;
	logic [1:0]  rw_r;
	logic        cl_ok_r;
	logic        vfmt_ok_r;
	logic        hdr_hit;
	logic        pkt_stb;
	logic        last;
	logic        body;
	logic        is_vid;
	logic        reg_ok;

	dhl_deser u_deser (
		.i_clk   (i_mddi_clk),
		.i_rst   (lrst),
		.i_bit   (i_mddi_data),
		.i_align (hdr_hit),
		.o_win   (win),
		.o_stb   (w_stb)
	);

	assign hdr_hit = lst_r == LK_SEEK && win == {PT_SUBFRAME, SUBFRAME_LEN};
	assign pkt_stb = lst_r == LK_PKT && w_stb;
	assign last    = wc_r == {1'b0, len_r[15:1]};
	assign body    = wc_r < {1'b0, len_r[15:1]};
	assign is_vid  = type_r == PT_VIDEO && cl_ok_r && vfmt_ok_r;
	assign reg_ok  = type_r == PT_REGACC && cl_ok_r && dest_r[15:1] == 15'h0000
		&& (rw_r == RW_WRITE || rw_r == RW_READ);

	always_ff @(posedge i_mddi_clk) begin
		if (lrst) begin
			lst_r <= LK_WAKE;
			zc_r  <= '0;
			wc_r  <= '0;
		end else begin
			case (lst_r)
				LK_WAKE: begin
					if (i_mddi_data) zc_r <= '0;
					else if (zc_r == WAKE_ZC_LAST) lst_r <= LK_SEEK;
					else zc_r <= zc_r + 6'h01;
				end
				LK_SEEK: begin
					if (hdr_hit) begin
						lst_r <= LK_PKT;
						wc_r  <= W_CLIENT;
					end
				end
				LK_PKT: begin
					if (w_stb && last) begin
						wc_r <= '0;
						if (type_r == PT_SHUTDOWN) begin
							lst_r <= LK_WAKE;
							zc_r  <= '0;
						end
					end else if (w_stb) begin
						wc_r <= wc_r + 16'h0001;
					end
				end
				default: lst_r <= LK_WAKE;
			endcase
		end
	end

	// Field capture; other packet types just run out their length
	always_ff @(posedge i_mddi_clk) begin
		if (lrst) begin
			len_r     <= '0;
			type_r    <= '0;
			sel_r     <= '0;
			dest_r    <= '0;
			rw_r      <= '0;
			cl_ok_r   <= 1'b0;
			vfmt_ok_r <= 1'b0;
		end else if (hdr_hit) begin
			len_r   <= SUBFRAME_LEN;
			type_r  <= PT_SUBFRAME;
			cl_ok_r <= 1'b1;
		end else if (pkt_stb) begin
			if (wc_r == 16'h0000) len_r <= w_word;
			if (wc_r == W_TYPE) type_r <= w_word;
			if (wc_r == W_CLIENT) cl_ok_r <= w_word == 16'h0000;
			if (wc_r == W_INFO) begin
				vfmt_ok_r <= dhl_desc_fmt(w_word) == lfmt && lfmt != 3'h0;
				rw_r      <= w_word[15:14];
			end
			if (wc_r == W_SEL) sel_r <= w_word;
			if (wc_r == W_DEST) dest_r <= w_word;
		end
	end

	always_ff @(posedge i_mddi_clk) begin
		if (lrst) begin
			hib_r        <= 1'b1;
			o_subframe   <= 1'b0;
			o_vid_word   <= '0;
			o_vid_mem_we <= 1'b0;
			o_vid_sub_we <= 1'b0;
		end else begin
			hib_r        <= lst_r == LK_WAKE;
			o_subframe   <= hdr_hit;
			if (pkt_stb) o_vid_word <= w_word;
			o_vid_mem_we <= pkt_stb && is_vid && body && wc_r >= W_VPIX
				&& sel_r[1:0] == ATTR_MEM;
			o_vid_sub_we <= pkt_stb && is_vid && body && wc_r >= W_VPIX
				&& sel_r[1:0] == ATTR_SUB;
		end
	end

	// Parameters are passed on until the CRC word, however many there are
	always_ff @(posedge i_mddi_clk) begin
		if (lrst) begin
			o_reg_req    <= '0;
			o_reg_rd_req <= 1'b0;
			o_reg_wr     <= 1'b0;
			o_reg_data   <= '0;
			o_reg_done   <= 1'b0;
		end else begin
			o_reg_rd_req <= pkt_stb && wc_r == W_DEST && type_r == PT_REGACC && cl_ok_r
				&& rw_r == RW_READ && w_word[15:1] == 15'h0000;
			if (pkt_stb && wc_r == W_DEST) begin
				o_reg_req.fwd   <= w_word == DEST_SUB;
				o_reg_req.index <= sel_r;
			end
			o_reg_wr   <= pkt_stb && reg_ok && rw_r == RW_WRITE && wc_r >= W_RPAR && body;
			if (pkt_stb) o_reg_data <= w_word;
			o_reg_done <= pkt_stb && last && reg_ok;
		end
	end

	a_wake_zeros: assert property (
		@(posedge i_mddi_clk) disable iff (lrst)
		lst_r == LK_WAKE && zc_r == WAKE_ZC_LAST && !i_mddi_data |=> lst_r == LK_SEEK)
		else $error("fortieth zero did not start the header search");
	a_wake_hold: assert property (
		@(posedge i_mddi_clk) disable iff (lrst)
		lst_r == LK_WAKE && i_mddi_data |=> lst_r == LK_WAKE && zc_r == 6'h00)
		else $error("a one did not restart the zero count");
	a_shutdown: assert property (
		@(posedge i_mddi_clk) disable iff (lrst)
		pkt_stb && last && type_r == PT_SHUTDOWN |=> lst_r == LK_WAKE ##1 hib_r)
		else $error("shutdown packet did not enter hibernation");
	a_vid_route: assert property (
		@(posedge i_mddi_clk) disable iff (lrst)
		o_vid_mem_we |-> !o_vid_sub_we && $past(sel_r[1:0]) == ATTR_MEM)
		else $error("memory write with wrong attribute");
	a_reg_code: assert property (
		@(posedge i_mddi_clk) disable iff (lrst)
		o_reg_wr |-> $past(rw_r) == RW_WRITE && !o_vid_mem_we)
		else $error("register write without write code");
	a_reg_route: assert property (
		@(posedge i_mddi_clk) disable iff (lrst)
		o_reg_rd_req |-> o_reg_req.fwd == ($past(w_word) == DEST_SUB))
		else $error("register read routed to the wrong port");
	a_vid_desc: assert property (
		@(posedge i_mddi_clk) disable iff (lrst) o_vid_mem_we || o_vid_sub_we |-> $past(vfmt_ok_r))
		else $error("video data passed with a disabled format");
	c_mem_write: cover property (@(posedge i_mddi_clk) disable iff (lrst) o_vid_mem_we);
	c_reg_read: cover property (@(posedge i_mddi_clk) disable iff (lrst) o_reg_rd_req);
endmodule

// ===== dhl_host.sv
`timescale 1ns/1ps
module dhl_host
	import dhl_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_dout,
	output dhl_ser_s  o_ser,
	output dhl_dpi_s  o_dpi,
	output logic      o_lclk,
	output logic      o_ldat
);
	initial begin
		o_ser = '{cs_n: 1'b1, scl: 1'b1, dcx: 1'b1, din: 1'b0};
		o_dpi = '{vs_n: 1'b1, hs_n: 1'b1, de: 1'b0, pclk: 1'b0, data: 18'h00000};
		o_lclk = 1'b0;
		o_ldat = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic ser_byte(input logic dcx, input logic [7:0] b, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		if (o_ser.cs_n) begin
			o_ser.cs_n = 1'b0;
			tick(4);
		end
		o_ser.dcx = dcx;
		for (int i = 0; i < n; i++) begin
			o_ser.scl = 1'b0;
			o_ser.din = b[7-i];
			tick(5);
			o_ser.scl = 1'b1;
			rd[7-i] = i_dout;
			tick(5);
		end
	endtask
	task automatic ser_end();
		o_ser.cs_n = 1'b1;
		// Released line flips so a stale bit is never mistaken for data
		o_ser.din = ~o_ser.din;
		tick(6);
	endtask
	task automatic pix(input logic de, input logic [17:0] d);
		o_dpi.pclk = 1'b0;
		o_dpi.de = de;
		o_dpi.data = de ? d : ~o_dpi.data;
		tick(3);
		o_dpi.pclk = 1'b1;
		tick(3);
	endtask
	// Shortened sync and porch counts keep the run brief
	task automatic dsync(input logic vs, input logic hs);
		o_dpi.vs_n = vs;
		o_dpi.hs_n = hs;
		pix(1'b0, 18'h00000);
		pix(1'b0, 18'h00000);
		o_dpi.vs_n = 1'b1;
		o_dpi.hs_n = 1'b1;
		pix(1'b0, 18'h00000);
	endtask
	// Strobe clock only toggles while bits are sent
	task automatic lbits(input int n, input logic v);
		repeat (n) begin
			o_ldat = v;
			#3 o_lclk = 1'b1;
			#3 o_lclk = 1'b0;
		end
	endtask
	task automatic lword(input logic [15:0] w);
		for (int i = 0; i < 16; i++) lbits(1, w[i]);
	endtask
endmodule

// ===== dhl_frontend_tb.sv
`timescale 1ns/1ps
module dhl_frontend_tb;
	import dhl_pkg::*;
	logic        i_clk, i_srst, i_mddi_clk, i_mddi_data, i_rd_active;
	logic [7:0]  i_rd_data, i_pixel_format, o_ser_byte, o_ser_index;
	logic        o_dout, o_dout_oe, o_ser_valid, o_ser_cmd, o_pix_valid;
	logic        o_frame_start, o_line_start, o_link_hib, o_subframe;
	logic        o_vid_mem_we, o_vid_sub_we, o_reg_rd_req, o_reg_wr, o_reg_done;
	logic [17:0] o_pix_data;
	logic [15:0] o_vid_word, o_reg_data;
	dhl_ser_s    i_ser;
	dhl_dpi_s    i_dpi;
	dhl_regreq_s o_reg_req;
	int          n_mismatch = 0, cmp_count = 0, seed = 32;
	int          n_frame = 0, n_line = 0, pcnt = 0;
	logic [31:0] eq[$], oq[$], pe[$], po[$], le[$], lo[$];

	dhl_frontend DUT (.i_clk, .i_srst, .i_mddi_clk, .i_mddi_data, .i_ser, .i_rd_data,
		.i_rd_active, .i_dpi, .i_pixel_format, .o_dout, .o_dout_oe, .o_ser_byte,
		.o_ser_valid, .o_ser_cmd, .o_ser_index, .o_pix_data, .o_pix_valid, .o_frame_start,
		.o_line_start, .o_link_hib, .o_subframe, .o_vid_word, .o_vid_mem_we, .o_vid_sub_we,
		.o_reg_req, .o_reg_rd_req, .o_reg_wr, .o_reg_data, .o_reg_done);
	dhl_host host (.i_clk(i_clk), .i_dout(o_dout), .o_ser(i_ser), .o_dpi(i_dpi),
		.o_lclk(i_mddi_clk), .o_ldat(i_mddi_data));

	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_ser_valid === 1'b1) oq.push_back({15'h0, o_ser_cmd, o_ser_index, o_ser_byte});
		if (o_pix_valid === 1'b1) po.push_back({14'h0, o_pix_data});
		if (o_frame_start === 1'b1) n_frame++;
		if (o_line_start === 1'b1) n_line++;
	end
	always @(posedge i_mddi_clk) if (i_srst === 1'b0) begin
		if (o_subframe === 1'b1) lo.push_back(32'h60000000);
		if (o_vid_mem_we === 1'b1) lo.push_back({16'h1000, o_vid_word});
		if (o_vid_sub_we === 1'b1) lo.push_back({16'h2000, o_vid_word});
		if (o_reg_wr === 1'b1) lo.push_back({15'h1800, o_reg_req.fwd, o_reg_data});
		if (o_reg_rd_req === 1'b1) lo.push_back({15'h2000, o_reg_req.fwd, o_reg_req.index});
		if (o_reg_done === 1'b1) lo.push_back({15'h2800, o_reg_req.fwd, o_reg_req.index});
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmpq(input string nm, ref logic [31:0] e[$], ref logic [31:0] o[$]);
		chk({nm, " count"}, e.size(), o.size());
		while (e.size() > 0 && o.size() > 0) chk(nm, e.pop_front(), o.pop_front());
		e.delete();
		o.delete();
	endtask
	task automatic results();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic sb(input logic dcx, input logic [7:0] b, output logic [7:0] r);
		host.ser_byte(dcx, b, 8, r);
		eq.push_back({15'h0, ~dcx, dcx ? 8'(pcnt) : 8'h00, b});
		pcnt = dcx ? pcnt + 1 : 0;
	endtask
	task automatic vid(input logic [15:0] desc, input logic [1:0] attr, input logic [15:0] cid);
		logic [15:0] p;
		logic        ok;
		logic [2:0]  f;
		f = i_pixel_format[FMT_LSB +: 3];
		ok = desc == {VDESC_TAG, 1'b1, COMP_6, COMP_6, COMP_6} && f == FMT_18BPP
			|| desc == {VDESC_TAG, 1'b1, COMP_5, COMP_6, COMP_5} && f == FMT_16BPP;
		ok = ok && !attr[1] == !attr[0];
		ok = ok && cid == 16'h0000;
		host.lword(16'h001E);
		host.lword(PT_VIDEO);
		host.lword(cid);
		host.lword(desc);
		host.lword({14'h0, attr});
		repeat (8) host.lword(16'h0000);
		repeat (2) begin
			p = 16'($random(seed));
			host.lword(p);
			if (ok) le.push_back({attr[0] ? 16'h1000 : 16'h2000, p});
		end
		host.lword(16'h0000);
	endtask
	task automatic regp(input logic [1:0] rw, input logic [15:0] dest, input int n);
		logic [15:0] p, idx;
		logic        ok;
		idx = 16'($random(seed));
		ok = (rw == RW_WRITE || rw == RW_READ) && dest <= DEST_SUB;
		host.lword(16'(2 * (7 + n)));
		host.lword(PT_REGACC);
		host.lword(16'h0000);
		host.lword({rw, 14'h0001});
		host.lword(idx);
		host.lword(dest);
		host.lword(16'h0000);
		if (ok && rw == RW_READ) le.push_back({15'h2000, dest[0], idx});
		for (int i = 0; i < n; i++) begin
			p = 16'($random(seed));
			host.lword(p);
			if (ok && rw == RW_WRITE) le.push_back({15'h1800, dest[0], p});
		end
		host.lword(16'h0000);
		if (ok) le.push_back({15'h2800, dest[0], idx});
	endtask

	initial begin
		#2000000;
		n_mismatch++;
		results();
	end
	initial begin
		logic [7:0]  r, b;
		logic [17:0] d;
		logic [2:0]  f;
		i_srst = 1'b1;
		i_rd_active = 1'b0;
		i_rd_data = 8'h00;
		i_pixel_format = {1'($random(seed)), FMT_18BPP, 4'($random(seed))};
		repeat (4) @(posedge i_clk);
		host.lbits(4, 1'b0);
		@(posedge i_clk);
		#1 i_srst = 1'b0;
		host.tick(5);
		chk("link_hib", 1, o_link_hib);
		b = 8'($random(seed));
		sb(1'b0, 8'hB3, r);
		sb(1'b1, 8'($random(seed)), r);
		host.ser_byte(1'b1, b, 3, r);
		host.ser_end();
		sb(1'b1, b, r);
		host.ser_end();
		sb(1'b1, 8'($random(seed)), r);
		host.ser_end();
		sb(1'b0, 8'h0C, r);
		i_rd_active = 1'b1;
		for (int k = 0; k < 2; k++) begin
			i_rd_data = 8'($random(seed));
			sb(1'b1, 8'h00, r);
			chk("read byte", i_rd_data, r);
		end
		chk("dout_oe", 1, o_dout_oe);
		host.ser_end();
		chk("dout_oe", 0, o_dout_oe);
		i_rd_active = 1'b0;
		cmpq("serial byte", eq, oq);
		for (int k = 0; k < 2; k++) begin
			f = k ? FMT_16BPP : FMT_18BPP;
			i_pixel_format = {1'($random(seed)), f, 4'($random(seed))};
			host.dsync(1'b0, 1'b1);
			for (int l = 0; l < 2; l++) begin
				host.dsync(1'b1, 1'b0);
				for (int j = 0; j < 4; j++) begin
					d = 18'($random(seed));
					host.pix(j != 2, d);
					if (j != 2) pe.push_back({14'h0, f == FMT_18BPP ? d : {2'b00, d[15:0]}});
				end
			end
		end
		host.tick(6);
		cmpq("pixel", pe, po);
		chk("frames", 2, n_frame);
		chk("lines", 4, n_line);
		i_pixel_format = {1'($random(seed)), FMT_18BPP, 4'($random(seed))};
		host.tick(4);
		host.lbits(30, 1'b0);
		host.lword(SUBFRAME_LEN);
		host.lword(PT_SUBFRAME);
		host.lbits(44, 1'b0);
		host.tick(5);
		chk("link_hib", 0, o_link_hib);
		host.lword(SUBFRAME_LEN);
		host.lword(PT_SUBFRAME);
		le.push_back(32'h60000000);
		repeat (9) host.lword(16'h0000);
		for (int a = 0; a < 4; a++) vid(16'h5666, 2'(a), 16'h0000);
		vid(16'h5565, 2'b11, 16'h0000);
		vid(16'h4666, 2'b11, 16'h0000);
		vid(16'h5666, 2'b11, 16'h0001);
		host.tick(1);
		i_pixel_format[FMT_LSB +: 3] = FMT_16BPP;
		vid(16'h5565, 2'b00, 16'h0000);
		vid(16'h5666, 2'b11, 16'h0000);
		host.tick(1);
		i_pixel_format[FMT_LSB +: 3] = FMT_18BPP;
		regp(RW_WRITE, DEST_MAIN, 3);
		regp(RW_READ, DEST_SUB, 0);
		regp(2'b01, DEST_MAIN, 1);
		regp(2'b11, DEST_MAIN, 1);
		regp(RW_WRITE, 16'h0002, 1);
		host.lword(16'h0006);
		host.lword(PT_SHUTDOWN);
		host.lword(16'h0000);
		host.lword(16'h0000);
		host.lbits(8, 1'b0);
		host.tick(5);
		chk("link_hib", 1, o_link_hib);
		cmpq("link event", le, lo);
		results();
	end
endmodule
